// ### rtl/ovs_pkg.sv
// package for the output-port video statistics counter bank
// assumes an 8-bit register read port with byte addresses as printed
package ovs_pkg;
  localparam int          CNT_W       = 16;
  localparam int          NUM_CNT     = 4;
  localparam logic [7:0]  ADDR_F0E_HI = 8'h92;
  localparam logic [7:0]  ADDR_F0E_LO = 8'h93;
  localparam logic [7:0]  ADDR_R0_HI  = 8'h94;
  localparam logic [7:0]  ADDR_R0_LO  = 8'h95;
  localparam logic [7:0]  ADDR_R0E_HI = 8'h96;
  localparam logic [7:0]  ADDR_R0E_LO = 8'h97;
  localparam logic [7:0]  ADDR_F1_HI  = 8'h98;
  localparam logic [7:0]  ADDR_F1_LO  = 8'h99;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  // one event per counter, index 0..3: bad frame p0, row p0, bad row p0, frame p1
  typedef struct packed {
    logic out1_image;
    logic out0_bad_row;
    logic out0_row;
    logic out0_bad_frame;
  } ovs_evt_s;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } ovs_rd_s;
endpackage : ovs_pkg

// ### rtl/ovs_tally.sv
// one 16-bit statistics counter with clear-on-read high byte and low snapshot
// assumes synchronous release of rst_n and one-cycle event and read pulses
`timescale 1ns/1ps
module ovs_tally (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         evt,
  input  wire logic         rd_hi,
  output logic [15:0]       count,
  output logic [7:0]        low_hold
);
  import ovs_pkg::*;

  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0]  low_r;
  logic [7:0]  low_nxt;

  always_comb begin
    count_nxt = count_r + 16'h0001;
    if (!evt) begin
      count_nxt = count_r;
    end
    low_nxt = low_r;
    if (rd_hi) begin
      // an event in the read cycle starts the new interval instead of being lost
      count_nxt = evt ? 16'h0001 : CNT_RST;
      low_nxt   = count_r[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_RST;
      low_r   <= BYTE_RST;
    end else begin
      count_r <= count_nxt;
      low_r   <= low_nxt;
    end
  end

  assign count    = count_r;
  assign low_hold = low_r;

  snap_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_hi |=> low_r == $past(count_r[7:0]))
    else $error("low holding byte missed the snapshot");
  clear_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_hi |=> count_r == {15'h0000, $past(evt)})
    else $error("counter not cleared by high read");
  count_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    (evt && !rd_hi) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance");
  hold_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_hi |=> $stable(low_r))
    else $error("holding byte changed without high read");
  wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
    count_r == 16'hffff ##1 count_r == 16'h0000);
endmodule : ovs_tally

// ### rtl/ovs_bank.sv
// top of the output-port video statistics counter bank
// assumes event inputs come from logic on CLOCK, one-cycle pulses per frame or line;
// register reads arrive on a one-cycle read strobe with a byte address
`timescale 1ns/1ps
module ovs_bank (
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  input  wire ovs_pkg::ovs_evt_s EVT,
  input  wire ovs_pkg::ovs_rd_s  RD,
  output logic [7:0]             RDATA,
  output logic                   RVALID
);
  import ovs_pkg::*;

  logic                rst_s1_r;
  logic                rst_n_r;
  logic                rst_n;
  logic [NUM_CNT-1:0]  evt_v;
  logic [NUM_CNT-1:0]  rd_hi_v;
  logic [15:0]         count_v [NUM_CNT];
  logic [7:0]          low_v   [NUM_CNT];
  logic [7:0]          rdata_r;
  logic [7:0]          rdata_nxt;
  logic                rvalid_r;
  logic                rvalid_nxt;

  // reset is released through two stages so every flop on rst_n leaves reset on the same edge
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign rst_n = rst_n_r;
  assign evt_v = EVT;

  // software owns read ordering; low reads never disturb the counters
  // a low read with no high read before it returns the previous snapshot, zero after reset
  assign rd_hi_v[0] = RD.rd && (RD.addr == ADDR_F0E_HI);
  assign rd_hi_v[1] = RD.rd && (RD.addr == ADDR_R0_HI);
  assign rd_hi_v[2] = RD.rd && (RD.addr == ADDR_R0E_HI);
  assign rd_hi_v[3] = RD.rd && (RD.addr == ADDR_F1_HI);

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_tally
    ovs_tally u_tally (
      .clk      (CLOCK),
      .rst_n    (rst_n),
      .evt      (evt_v[i]),
      .rd_hi    (rd_hi_v[i]),
      .count    (count_v[i]),
      .low_hold (low_v[i])
    );
  end

  // read data is registered: high byte taken before the clear lands
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = RD.rd;
    if (RD.rd) begin
      unique case (RD.addr)
        ADDR_F0E_HI: rdata_nxt = count_v[0][15:8];
        ADDR_F0E_LO: rdata_nxt = low_v[0];
        ADDR_R0_HI:  rdata_nxt = count_v[1][15:8];
        ADDR_R0_LO:  rdata_nxt = low_v[1];
        ADDR_R0E_HI: rdata_nxt = count_v[2][15:8];
        ADDR_R0E_LO: rdata_nxt = low_v[2];
        ADDR_F1_HI:  rdata_nxt = count_v[3][15:8];
        ADDR_F1_LO:  rdata_nxt = low_v[3];
        default:     rdata_nxt = UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r  <= BYTE_RST;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign RDATA  = rdata_r;
  assign RVALID = rvalid_r;

  hi_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_HI) |=> RDATA == $past(count_v[1][15:8]))
    else $error("row tally high byte wrong");
  pair_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F1_HI) ##1 (RD.rd && RD.addr == ADDR_F1_LO)
    |=> RDATA == $past(count_v[3][7:0], 2))
    else $error("image tally pair not from one snapshot");
  lo_keep_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0E_LO) |=> count_v[2] == $past(count_v[2])
    + {15'h0000, $past(evt_v[2])})
    else $error("low read disturbed counter");
  unmapped_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == 8'h90) |=> RDATA == UNMAPPED_RD && RVALID)
    else $error("unmapped read not zero");
  reset_zero_a: assert property (@(posedge CLOCK)
    $rose(rst_n) |-> count_v[0] == CNT_RST && low_v[0] == BYTE_RST)
    else $error("counter not zero after reset");
  rd_valid_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    RD.rd |=> RVALID)
    else $error("read answer missing");
  pair_c: cover property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_HI) ##1 (RD.rd && RD.addr == ADDR_F0E_LO));
  evt_rd_c: cover property (@(posedge CLOCK) disable iff (!rst_n)
    EVT.out0_row && RD.rd && RD.addr == ADDR_R0_HI);
  busy_c: cover property (@(posedge CLOCK) disable iff (!rst_n)
    count_v[2] == 16'h0100);
  row_wrap_c: cover property (@(posedge CLOCK) disable iff (!rst_n)
    EVT.out0_row && count_v[1] == 16'hffff);

  // each high read answers with the live upper byte of its own counter
  hi_bf_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_HI) |=> RDATA == $past(count_v[0][15:8]))
    else $error("bad-frame tally high byte wrong");
  hi_br_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0E_HI) |=> RDATA == $past(count_v[2][15:8]))
    else $error("bad-row tally high byte wrong");
  hi_img_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F1_HI) |=> RDATA == $past(count_v[3][15:8]))
    else $error("image tally high byte wrong");

  // and clears only its own counter; an event in that cycle survives as a count of one
  clear_bf_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_HI) |=> count_v[0] == {15'h0000, $past(evt_v[0])})
    else $error("bad-frame tally not cleared by its high read");
  clear_row_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_HI) |=> count_v[1] == {15'h0000, $past(evt_v[1])})
    else $error("row tally not cleared by its high read");
  clear_br_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0E_HI) |=> count_v[2] == {15'h0000, $past(evt_v[2])})
    else $error("bad-row tally not cleared by its high read");
  clear_img_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F1_HI) |=> count_v[3] == {15'h0000, $past(evt_v[3])})
    else $error("image tally not cleared by its high read");
  cross_keep_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_HI) |=> count_v[0] == $past(count_v[0])
    + {15'h0000, $past(evt_v[0])})
    else $error("row high read disturbed bad-frame tally");

  // a low read answers from the holding byte, never from the live counter
  lo_bf_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_LO) |=> RDATA == $past(low_v[0]))
    else $error("bad-frame tally low byte not the held one");
  lo_row_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_LO) |=> RDATA == $past(low_v[1]))
    else $error("row tally low byte not the held one");
  lo_br_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0E_LO) |=> RDATA == $past(low_v[2]))
    else $error("bad-row tally low byte not the held one");
  lo_img_read_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F1_LO) |=> RDATA == $past(low_v[3]))
    else $error("image tally low byte not the held one");

  // a high read followed by a low read gives both halves of one snapshot
  pair_bf_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_HI) ##1 (RD.rd && RD.addr == ADDR_F0E_LO)
    |=> RDATA == $past(count_v[0][7:0], 2))
    else $error("bad-frame tally pair not from one snapshot");
  pair_row_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_HI) ##1 (RD.rd && RD.addr == ADDR_R0_LO)
    |=> RDATA == $past(count_v[1][7:0], 2))
    else $error("row tally pair not from one snapshot");
  pair_br_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0E_HI) ##1 (RD.rd && RD.addr == ADDR_R0E_LO)
    |=> RDATA == $past(count_v[2][7:0], 2))
    else $error("bad-row tally pair not from one snapshot");

  // low reads leave the counters to their events
  keep_bf_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F0E_LO) |=> count_v[0] == $past(count_v[0])
    + {15'h0000, $past(evt_v[0])})
    else $error("low read disturbed bad-frame tally");
  keep_row_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_R0_LO) |=> count_v[1] == $past(count_v[1])
    + {15'h0000, $past(evt_v[1])})
    else $error("low read disturbed row tally");
  keep_img_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && RD.addr == ADDR_F1_LO) |=> count_v[3] == $past(count_v[3])
    + {15'h0000, $past(evt_v[3])})
    else $error("low read disturbed image tally");

  // the top count rolls over to zero rather than sticking
  row_wrap_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (count_v[1] == 16'hffff && evt_v[1] && !rd_hi_v[1]) |=> count_v[1] == CNT_RST)
    else $error("row tally did not wrap to zero");

  // every counter and holding byte leaves reset at zero
  reset_all_a: assert property (@(posedge CLOCK)
    $rose(rst_n) |-> count_v[1] == CNT_RST && count_v[2] == CNT_RST
    && count_v[3] == CNT_RST && low_v[1] == BYTE_RST && low_v[2] == BYTE_RST
    && low_v[3] == BYTE_RST && RDATA == BYTE_RST && !RVALID)
    else $error("bank not zero after reset");

  // the answer is a single-cycle pulse and the data stands until the next read
  rv_idle_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !RD.rd |=> !RVALID)
    else $error("read answer without a read");
  rdata_hold_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !RD.rd |=> $stable(RDATA))
    else $error("read data moved without a read");
  unmapped_all_a: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD.rd && !(RD.addr inside {[ADDR_F0E_HI:ADDR_F1_LO]})) |=> RDATA == UNMAPPED_RD)
    else $error("read outside the bank not zero");
endmodule : ovs_bank

// ### test/ovs_bank_tb.sv
// self-checking bench for the output-port video statistics counter bank
// assumes a one-cycle read answer and events counted on the rising edge
`timescale 1ns/1ps
module ovs_bank_tb;
  import ovs_pkg::*;
  logic        CLOCK;
  logic        RESETN;
  ovs_evt_s    EVT;
  ovs_rd_s     RD;
  logic [7:0]  RDATA;
  logic        RVALID;
  int          mismatches;
  int          check_count;
  int unsigned seed;
  int          cnt[4];
  int          hold[4];

  ovs_bank i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .EVT(EVT), .RD(RD), .RDATA(RDATA),
                  .RVALID(RVALID));

  initial CLOCK = 1'b0;
  always #2.5 CLOCK = ~CLOCK;

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // inputs change at the falling edge; the answer is looked at one falling edge later
  task automatic cyc(input logic [3:0] ev, input logic rd, input logic [7:0] addr);
    int         idx;
    logic [7:0] exp;
    idx = (int'(addr) - 'h90) / 2 - 1;
    exp = 8'h00;
    EVT = ev;
    RD  = {rd, addr};
    for (int i = 0; i < 4; i++) begin
      if (rd && idx == i && !addr[0]) begin
        exp     = 8'(cnt[i] >> 8);
        hold[i] = cnt[i] & 'hff;
        cnt[i]  = ev[i];
      end else begin
        if (rd && idx == i)
          exp = 8'(hold[i]);
        cnt[i] = (cnt[i] + ev[i]) & 'hffff;
      end
    end
    @(negedge CLOCK);
    check("rvalid", {7'h00, RVALID}, {7'h00, rd});
    if (rd)
      check("rdata", RDATA, exp);
  endtask : cyc

  task automatic do_reset();
    EVT    = '0;
    RD     = '0;
    RESETN = 1'b0;
    cnt    = '{0, 0, 0, 0};
    hold   = '{0, 0, 0, 0};
    repeat (6) @(negedge CLOCK);
    RESETN = 1'b1;
    // two-flop release: first access from the third edge on
    repeat (3) @(negedge CLOCK);
  endtask : do_reset

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    seed        = 16338;
    mismatches  = 0;
    check_count = 0;
    do_reset();
    for (int a = 'h90; a < 'ha0; a++)
      cyc(4'h0, 1'b1, 8'(a));
    for (int i = 0; i < 4; i++) begin
      repeat (300) cyc(4'(xs()), 1'b0, 8'h00);
      cyc(4'(xs()), 1'b1, 8'(8'h92 + 2 * i));
      cyc(4'(xs()), 1'b1, 8'(8'h93 + 2 * i));
    end
    // back-to-back reads, low before high and reads colliding with events
    repeat (3000) cyc(4'(xs()), xs() % 3 == 0, 8'(8'h90 + xs() % 12));
    // drive the row tally past its top
    repeat (65537) cyc(4'h2, 1'b0, 8'h00);
    cyc(4'h0, 1'b1, 8'h94);
    cyc(4'h0, 1'b1, 8'h95);
    repeat (50) cyc(4'hf, 1'b0, 8'h00);
    do_reset();
    for (int a = 'h92; a < 'h9a; a++)
      cyc(4'h0, 1'b1, 8'(a));
    stop_test();
  end
endmodule : ovs_bank_tb
